// ---- homing_pkg.sv ----
package homing_pkg;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0] SPEED_OFFSET = 8'h00;
	localparam logic [7:0] MODE_OFFSET = 8'h04;
	localparam logic [7:0] REVERSE_TRAVEL_OFFSET = 8'h08;
	localparam logic [7:0] SHIFT_OFFSET = 8'h0C;
	localparam logic [7:0] HOME_VALUE_OFFSET = 8'h10;
	localparam logic [7:0] DETECT_RANGE_OFFSET = 8'h14;
	localparam logic [7:0] STATUS_OFFSET = 8'h18;
	localparam logic [7:0] EFFECTIVE_TRAVEL_OFFSET = 8'h1C;

	// ==========================================================
	// Field positions
	localparam int HOMING_SPEED_LSB = 0;
	localparam int CREEP_SPEED_LSB = 16;
	localparam int START_SEL_LSB = 0;
	localparam int POST_DIR_BIT = 2;
	localparam int SHIFT_REF_LSB = 4;
	localparam int HOMING_REF_LSB = 8;
	localparam int EDGE_SEL_BIT = 12;
	localparam int CREEP_REV_BIT = 13;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_COMPLETE_BIT = 1;
	localparam int STAT_HOME_BIT = 2;
	localparam int STAT_STATE_LSB = 4;

	// ==========================================================
	// Reset values (speeds in 0.01 r/min)
	localparam logic [15:0] HOMING_SPEED_RESET = 16'hC350;
	localparam logic [15:0] CREEP_SPEED_RESET = 16'h1388;
	localparam logic [1:0] START_SEL_RESET = 2'h0;
	localparam logic POST_DIR_RESET = 1'b0;
	localparam logic [2:0] SHIFT_REF_RESET = 3'h1;
	localparam logic [1:0] HOMING_REF_RESET = 2'h0;
	localparam logic EDGE_SEL_RESET = 1'b0;
	localparam logic CREEP_REV_RESET = 1'b0;
	localparam logic [31:0] REVERSE_TRAVEL_RESET = 32'h0000_0000;
	localparam logic [31:0] SHIFT_RESET = 32'h0000_03E8;
	localparam logic [31:0] HOME_VALUE_RESET = 32'h0000_0000;
	localparam logic [31:0] DETECT_RANGE_RESET = 32'h0000_0000;

	// ==========================================================
	// Setting encodings
	localparam logic [1:0] START_CONDITION = 2'h2;
	localparam logic [2:0] SHIFT_REF_SWITCH = 3'h0;
	localparam logic [2:0] SHIFT_REF_INDEX = 3'h1;
	localparam logic [1:0] HOMING_REF_SWITCH = 2'h0;

	// ==========================================================
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Timing
	localparam int CLOCK_PERIOD_PS = 5000;
	localparam int REVERSAL_PAUSE_NS = 1000;
	localparam int REVERSAL_PAUSE_CYCLES = (REVERSAL_PAUSE_NS * 1000) / CLOCK_PERIOD_PS;

	// ==========================================================
	// Sequencer states, Gray coded in the order listed
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_FAST = 3'h1,
		ST_PAUSE = 3'h3,
		ST_BACKOFF = 3'h2,
		ST_CREEP = 3'h6,
		ST_SHIFT = 3'h7
	} seq_state_t;

endpackage

// ---- edge_sense.sv ----
`timescale 1ns/1ps
`default_nettype none

module edge_sense (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic level,
	output logic rise,
	output logic fall
);

	logic last;

	// ==========================================================
	// Edge pulses, one cycle after the transition
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last <= level;
			rise <= 1'b0;
			fall <= 1'b0;
		end else begin
			last <= level;
			rise <= level & ~last;
			fall <= ~level & last;
		end
	end

endmodule

`default_nettype wire

// ---- homing_sequencer.sv ----
// Operation
// - Request rising edge starts motion in start direction at homing speed.
// - Reverse start: on switch, turn to homing direction at creep speed.
// - First index after switch: travel shift amount, stop, flag complete.
// - Zero speed and in-position pulse briefly at each reversal.
// - Start setting 2 picks direction from homing direction and switch state.
// - Edge select 0 uses switch ON edge, 1 uses OFF edge.
// - Condition start valid for shift ref switch, or index with switch ref.
// - Unqualified condition start uses homing direction as start direction.
// - Condition start forces reverse travel amount to zero.
// - Condition start: switch release stops briefly, then creep homing direction.
// - Start on switch: reverse at homing speed, slow to creep on release.
// - Condition start: first index after switch rising edge starts shift.
// - Start off switch with reverse enable: forward, reverse on switch rise.
// - After that reversal, switch falling edge turns back forward.
// - Shift reference 1 uses index pulse, 0 uses home switch.
// - Detect range 0 holds home-position output on after completion.
// - Forward means increasing position, reverse decreasing.
`timescale 1ns/1ps
`default_nettype none

module homing_sequencer #(
	parameter int PAUSE_CYCLES = homing_pkg::REVERSAL_PAUSE_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic homing_request,
	input wire logic home_switch,
	input wire logic encoder_index,
	input wire logic signed [31:0] actual_position,
	output logic [15:0] speed_command,
	output logic reverse_direction,
	output logic zero_speed,
	output logic in_position,
	output logic homing_busy,
	output logic homing_complete,
	output logic home_position,
	output logic preset_strobe,
	output logic [31:0] preset_value
);

	import homing_pkg::*;

	// ==========================================================
	// Configuration registers
	logic [15:0] homing_speed;
	logic [15:0] creep_speed;
	logic [1:0] start_direction_select;
	logic post_reference_direction;
	logic [2:0] shift_reference_select;
	logic [1:0] homing_reference_select;
	logic switch_edge_select;
	logic creep_decel_reverse_enable;
	logic [31:0] reverse_travel_amount;
	logic [31:0] home_shift_amount;
	logic [31:0] home_position_value;
	logic [31:0] home_detect_range;

	// Bus slave state
	logic aw_got;
	logic w_got;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	// Sequencer state
	seq_state_t state;
	seq_state_t pause_target;
	logic move_dir;
	logic cond_profile;
	logic started_on_switch;
	logic armed;
	logic [15:0] pause_count;
	logic signed [31:0] shift_origin;

	// Edge events
	logic [2:0] levels;
	logic [2:0] rises;
	logic [2:0] falls;
	logic req_rise;
	logic sw_rise;
	logic sw_fall;
	logic idx_rise;
	logic ref_edge;

	// Start decisions
	logic cond_select;
	logic cond_qualified;
	logic start_dir;
	logic [31:0] effective_reverse_travel;
	logic signed [32:0] travelled;
	logic signed [32:0] home_error;
	logic shift_by_switch;

	// ==========================================================
	// Edges of request, switch and index
	assign levels = {encoder_index, home_switch, homing_request};

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gen_edge
			edge_sense edge_unit (
				.aclk(aclk),
				.aresetn(aresetn),
				.level(levels[g]),
				.rise(rises[g]),
				.fall(falls[g])
			);
		end
	endgenerate

	assign req_rise = rises[0];
	assign sw_rise = rises[1];
	assign sw_fall = falls[1];
	assign idx_rise = rises[2];

	assign ref_edge = switch_edge_select ? sw_fall : sw_rise;
	assign shift_by_switch = (shift_reference_select == SHIFT_REF_SWITCH);

	// ==========================================================
	// Start direction selection
	// condition start
	assign cond_select = (start_direction_select == START_CONDITION);
	assign cond_qualified = shift_by_switch ||
		((shift_reference_select == SHIFT_REF_INDEX) && (homing_reference_select == HOMING_REF_SWITCH));

	// Reverse is 1; a switch already on puts home behind us
	always_comb begin
		if (cond_select && cond_qualified) begin
			start_dir = home_switch ? ~post_reference_direction : post_reference_direction;
		end else if (cond_select) begin
			start_dir = post_reference_direction;
		end else begin
			start_dir = start_direction_select[0];
		end
	end

	assign effective_reverse_travel = cond_select ? 32'h0000_0000 : reverse_travel_amount;

	assign travelled = post_reference_direction ?
		({shift_origin[31], shift_origin} - {actual_position[31], actual_position}) :
		({actual_position[31], actual_position} - {shift_origin[31], shift_origin});

	assign home_error = {actual_position[31], actual_position} -
		{home_position_value[31], home_position_value};

	// ==========================================================
	// Write channel: address and data in either order
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] result;
		result = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				result[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return result;
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (aw_got && w_got && !s_axi_bvalid) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr[7:5] == 3'h0 && aw_addr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
			end
			// Ready again after the response: one write at a time
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Register storage, written as the pair completes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			homing_speed <= HOMING_SPEED_RESET;
			creep_speed <= CREEP_SPEED_RESET;
			start_direction_select <= START_SEL_RESET;
			post_reference_direction <= POST_DIR_RESET;
			shift_reference_select <= SHIFT_REF_RESET;
			homing_reference_select <= HOMING_REF_RESET;
			switch_edge_select <= EDGE_SEL_RESET;
			creep_decel_reverse_enable <= CREEP_REV_RESET;
			reverse_travel_amount <= REVERSE_TRAVEL_RESET;
			home_shift_amount <= SHIFT_RESET;
			home_position_value <= HOME_VALUE_RESET;
			home_detect_range <= DETECT_RANGE_RESET;
		end else if (aw_got && w_got && !s_axi_bvalid) begin
			case (aw_addr)
				SPEED_OFFSET: begin
					{creep_speed, homing_speed} <= merge({creep_speed, homing_speed}, w_data, w_strb);
				end
				MODE_OFFSET: begin
					// Direction settings hold while a sequence runs
					if (state == ST_IDLE && w_strb[0]) begin
						start_direction_select <= w_data[START_SEL_LSB +: 2];
						post_reference_direction <= w_data[POST_DIR_BIT];
						shift_reference_select <= w_data[SHIFT_REF_LSB +: 3];
					end
					if (state == ST_IDLE && w_strb[1]) begin
						homing_reference_select <= w_data[HOMING_REF_LSB +: 2];
						switch_edge_select <= w_data[EDGE_SEL_BIT];
						creep_decel_reverse_enable <= w_data[CREEP_REV_BIT];
					end
				end
				REVERSE_TRAVEL_OFFSET: begin
					reverse_travel_amount <= merge(reverse_travel_amount, w_data, w_strb);
				end
				SHIFT_OFFSET: begin
					home_shift_amount <= merge(home_shift_amount, w_data, w_strb);
				end
				HOME_VALUE_OFFSET: begin
					home_position_value <= merge(home_position_value, w_data, w_strb);
				end
				DETECT_RANGE_OFFSET: begin
					home_detect_range <= merge(home_detect_range, w_data, w_strb);
				end
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// Read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			case (s_axi_araddr)
				SPEED_OFFSET: s_axi_rdata <= {creep_speed, homing_speed};
				MODE_OFFSET: s_axi_rdata <= {18'h0, creep_decel_reverse_enable, switch_edge_select,
					2'h0, homing_reference_select, 1'b0, shift_reference_select,
					1'b0, post_reference_direction, start_direction_select};
				REVERSE_TRAVEL_OFFSET: s_axi_rdata <= reverse_travel_amount;
				SHIFT_OFFSET: s_axi_rdata <= home_shift_amount;
				HOME_VALUE_OFFSET: s_axi_rdata <= home_position_value;
				DETECT_RANGE_OFFSET: s_axi_rdata <= home_detect_range;
				STATUS_OFFSET: s_axi_rdata <= {25'h0, state, 1'b0, home_position,
					homing_complete, homing_busy};
				EFFECTIVE_TRAVEL_OFFSET: s_axi_rdata <= effective_reverse_travel;
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ==========================================================
	// Homing sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			pause_target <= ST_IDLE;
			move_dir <= 1'b0;
			cond_profile <= 1'b0;
			started_on_switch <= 1'b0;
			armed <= 1'b0;
			pause_count <= 16'h0000;
			shift_origin <= 32'sh0000_0000;
		end else begin
			case (state)
				ST_IDLE: begin
					if (req_rise) begin
						state <= ST_FAST;
						move_dir <= start_dir;
						cond_profile <= cond_select && cond_qualified;
						started_on_switch <= home_switch;
						armed <= 1'b0;
					end
				end
				ST_FAST: begin
					if (cond_profile && started_on_switch) begin
						// release: brief stop, creep toward home
						if (sw_fall) begin
							state <= ST_PAUSE;
							pause_target <= ST_CREEP;
							pause_count <= 16'(PAUSE_CYCLES);
						end
					end else if (cond_profile) begin
						if (sw_rise && creep_decel_reverse_enable) begin
							state <= ST_PAUSE;
							pause_target <= ST_BACKOFF;
							pause_count <= 16'(PAUSE_CYCLES);
						end else if (sw_rise) begin
							state <= ST_CREEP;
							armed <= ~switch_edge_select;
						end
					end else if (ref_edge) begin
						armed <= 1'b1;
						if (move_dir != post_reference_direction) begin
							state <= ST_PAUSE;
							pause_target <= ST_CREEP;
							pause_count <= 16'(PAUSE_CYCLES);
						end else if (shift_by_switch) begin
							state <= ST_SHIFT;
							shift_origin <= actual_position;
						end else begin
							state <= ST_CREEP;
						end
					end
				end
				ST_PAUSE: begin
					if (pause_count <= 16'h0001) begin
						state <= pause_target;
						move_dir <= (pause_target == ST_BACKOFF) ? ~post_reference_direction :
							post_reference_direction;
					end else begin
						pause_count <= pause_count - 16'h0001;
					end
				end
				ST_BACKOFF: begin
					if (sw_fall) begin
						state <= ST_PAUSE;
						pause_target <= ST_CREEP;
						pause_count <= 16'(PAUSE_CYCLES);
					end
				end
				ST_CREEP: begin
					if (ref_edge && shift_by_switch) begin
						state <= ST_SHIFT;
						shift_origin <= actual_position;
					end else if (armed && idx_rise && !shift_by_switch) begin
						state <= ST_SHIFT;
						shift_origin <= actual_position;
					end else if (ref_edge) begin
						armed <= 1'b1;
					end
				end
				ST_SHIFT: begin
					if (travelled >= $signed({1'b0, home_shift_amount})) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Motion outputs, one cycle behind the state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			speed_command <= 16'h0000;
			reverse_direction <= 1'b0;
			zero_speed <= 1'b1;
			in_position <= 1'b0;
			homing_busy <= 1'b0;
		end else begin
			case (state)
				ST_FAST: speed_command <= homing_speed;
				ST_BACKOFF, ST_CREEP, ST_SHIFT: speed_command <= creep_speed;
				default: speed_command <= 16'h0000;
			endcase
			reverse_direction <= move_dir;
			zero_speed <= (state == ST_IDLE) || (state == ST_PAUSE);
			in_position <= (state == ST_PAUSE) || (state == ST_IDLE && homing_complete);
			homing_busy <= (state != ST_IDLE);
		end
	end

	// ==========================================================
	// Completion, preset and home flag
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			homing_complete <= 1'b0;
			home_position <= 1'b0;
			preset_strobe <= 1'b0;
			preset_value <= 32'h0000_0000;
		end else begin
			preset_strobe <= 1'b0;
			if (state == ST_SHIFT && travelled >= $signed({1'b0, home_shift_amount})) begin
				// Stop point takes the home value
				homing_complete <= 1'b1;
				preset_strobe <= 1'b1;
				preset_value <= home_position_value;
			end else if (state == ST_IDLE && req_rise) begin
				homing_complete <= 1'b0;
			end
			if (home_detect_range == 32'h0000_0000) begin
				home_position <= homing_complete;
			end else begin
				home_position <= homing_complete &&
					(home_error <= $signed({1'b0, home_detect_range})) &&
					(home_error >= -$signed({1'b0, home_detect_range}));
			end
		end
	end

endmodule

`default_nettype wire

// ---- homing_sequencer_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none

module homing_sequencer_monitor
	import homing_pkg::*;
#(
	parameter int PAUSE_CYCLES = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic homing_request,
	input wire logic [15:0] speed_command,
	input wire logic reverse_direction,
	input wire logic zero_speed,
	input wire logic in_position,
	input wire logic homing_busy,
	input wire logic homing_complete,
	input wire logic home_position,
	input wire logic preset_strobe,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid
);
	default clocking dcb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ==========================================
	// Pause length
	int pause_cnt;

	// Consecutive pause cycles
	always_ff @(posedge aclk) begin
		if (!aresetn || !(zero_speed && homing_busy)) begin
			pause_cnt <= 0;
		end else begin
			pause_cnt <= pause_cnt + 1;
		end
	end

	// ==========================================
	// Sequences
	sequence req_idle;
		$rose(homing_request) && !homing_busy;
	endsequence
	sequence fast_run;
		##3 homing_busy && speed_command == HOMING_SPEED_RESET;
	endsequence
	sequence pause_end;
		$fell(zero_speed) && homing_busy && $past(homing_busy);
	endsequence

	// ==========================================
	// Properties
	AST_START: assert property (req_idle |-> fast_run)
		else $error("no start");
	AST_IGNORE: assert property (homing_busy && $rose(homing_request)
		&& speed_command == CREEP_SPEED_RESET |-> ##3 speed_command != HOMING_SPEED_RESET)
		else $error("restarted");
	AST_PAUSE_OUT: assert property (zero_speed && homing_busy
		|-> in_position && speed_command == 16'h0000)
		else $error("pause outputs");
	AST_PAUSE_LEN: assert property (pause_end
		|-> pause_cnt >= PAUSE_CYCLES - 1 && pause_cnt <= PAUSE_CYCLES + 1)
		else $error("pause length");
	AST_REV_AT_ZERO: assert property (homing_busy && $changed(reverse_direction)
		|-> zero_speed || $past(zero_speed))
		else $error("flip at speed");
	AST_DONE: assert property ($rose(homing_complete) |-> ##[0:2] preset_strobe)
		else $error("no preset");
	// Bench keeps detect range at zero
	AST_HOLD: assert property (homing_complete && $past(homing_complete)
		|-> home_position)
		else $error("home dropped");
	AST_IDLE: assert property (!homing_busy && !$past(homing_busy)
		|-> speed_command == 16'h0000 && zero_speed)
		else $error("motion while idle");
	AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready // AXI
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("bvalid dropped");
	AST_RANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) // AXI
		else $error("no rvalid");
endmodule

bind homing_sequencer homing_sequencer_monitor #(
	.PAUSE_CYCLES(PAUSE_CYCLES)
) homing_sequencer_monitor_i (
	.aclk, .aresetn, .homing_request, .speed_command, .reverse_direction,
	.zero_speed, .in_position, .homing_busy, .homing_complete, .home_position,
	.preset_strobe, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid
);

`default_nettype wire

// ---- homing_far_side.sv ----
`timescale 1ns/1ps
`default_nettype none

module homing_far_side #(
	parameter int SWITCH_AT = 32'h834
) (
	input wire logic aclk,
	input wire logic [15:0] speed_command,
	input wire logic reverse_direction,
	input wire logic load,
	input wire logic signed [31:0] load_pos,
	output logic home_switch,
	output logic encoder_index,
	output var logic signed [31:0] actual_position
);
	logic signed [31:0] step;
	logic signed [31:0] next_pos;

	// ==========================================
	// Motor and encoder
	// Coarse step keeps runs short; no ramps modelled
	assign step = $signed({28'h0000000, speed_command[15:12]}) + 32'sh1;
	assign next_pos = reverse_direction ? actual_position - step : actual_position + step;

	// Moves only under a speed command; index every 512 counts
	always_ff @(posedge aclk) begin
		encoder_index <= 1'b0;
		if (load) begin
			actual_position <= load_pos;
		end else if (speed_command != 16'h0000) begin
			actual_position <= next_pos;
			encoder_index <= next_pos[31:9] != actual_position[31:9];
		end
	end

	// Switch on from its edge to the far end
	assign home_switch = actual_position >= SWITCH_AT;
endmodule

`default_nettype wire

// ---- homing_sequencer_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module homing_sequencer_tb_top;
	import homing_pkg::*;

	localparam logic signed [31:0] STOP_LO = 32'sh0A00 + $signed(SHIFT_RESET);
	localparam logic [31:0] MODE_COND = 32'h0000_2012;

	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, preset_value;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_bready = 1'b0, s_axi_rready = 1'b0, homing_request = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic home_switch, encoder_index, reverse_direction, zero_speed, in_position;
	logic homing_busy, homing_complete, home_position, preset_strobe;
	logic [15:0] speed_command;
	logic signed [31:0] actual_position;
	logic signed [31:0] load_pos = 32'sh0;
	logic load = 1'b1;
	int err_total = 0;
	int total_checks = 0;

	// ==========================================
	// Design, far side, clock
	homing_sequencer #(.PAUSE_CYCLES(4)) homing_sequencer_i (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .homing_request, .home_switch,
		.encoder_index, .actual_position, .speed_command, .reverse_direction,
		.zero_speed, .in_position, .homing_busy, .homing_complete, .home_position,
		.preset_strobe, .preset_value
	);
	homing_far_side homing_far_side_i (
		.aclk, .speed_command, .reverse_direction, .load, .load_pos,
		.home_switch, .encoder_index, .actual_position
	);
	always #2.5 aclk = ~aclk;

	// ==========================================
	// Shared tasks
	task automatic chk(input logic ok, input string what);
		total_checks++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("[ERR] %0t mismatch: %s", $time, what);
		end
	endtask

	task automatic report_and_stop;
		if (err_total == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic hang(input string what);
		err_total++;
		$display("[ERR] %0t timeout: %s", $time, what);
		report_and_stop();
	endtask

	// Write: each channel held to its own ready
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; s_axi_bvalid !== 1'b1; n++) begin
			@(posedge aclk);
			if (n > 50) hang("write");
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp === er, "write response");
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; s_axi_rvalid !== 1'b1; n++) begin
			@(posedge aclk);
			if (n > 50) hang("read");
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata === ed && s_axi_rresp === er, "read data");
	endtask

	task automatic place(input logic signed [31:0] p);
		@(posedge aclk);
		load <= 1'b1;
		load_pos <= p;
		@(posedge aclk);
		load <= 1'b0;
	endtask

	// Request edge; start shows three edges on
	task automatic go(input logic exp_rev);
		@(posedge aclk);
		homing_request <= 1'b1;
		repeat (3) @(posedge aclk);
		#1;
		chk(homing_busy === 1'b1 && speed_command === HOMING_SPEED_RESET, "no start");
		chk(reverse_direction === exp_rev, "start direction");
		@(posedge aclk);
		homing_request <= 1'b0;
	endtask

	task automatic finish_run(output logic saw_rev, output logic saw_pause);
		int n;
		int k = 0;
		logic saw_strobe = 1'b0;
		saw_rev = 1'b0;
		saw_pause = 1'b0;
		for (n = 0; k < 6; n++) begin
			@(posedge aclk);
			if (n > 20000) hang("homing");
			saw_rev |= reverse_direction;
			saw_pause |= zero_speed & in_position & homing_busy;
			saw_strobe |= preset_strobe;
			if (homing_complete === 1'b1) k++;
		end
		#1;
		chk(saw_strobe && preset_value === HOME_VALUE_RESET, "preset");
		chk(home_position === 1'b1 && homing_busy === 1'b0, "home flag");
		chk(speed_command === 16'h0000, "not stopped");
		chk(actual_position >= STOP_LO && actual_position < STOP_LO + 32'sh40, "stop");
	endtask

	// ==========================================
	// Scenarios
	task automatic sc_default;
		logic r, p;
		int n;
		place(32'sh0);
		go(1'b0);
		for (n = 0; speed_command !== CREEP_SPEED_RESET; n++) begin
			@(posedge aclk);
			if (n > 2000) hang("creep");
		end
		homing_request <= 1'b1;
		repeat (3) @(posedge aclk);
		#1;
		chk(homing_busy === 1'b1 && speed_command !== HOMING_SPEED_RESET, "restart");
		@(posedge aclk);
		homing_request <= 1'b0;
		finish_run(r, p);
		chk(r === 1'b0, "needless reversal");
		axi_rd(STATUS_OFFSET, 32'h0000_0006, RESP_OKAY);
	endtask

	task automatic sc_regs;
		axi_rd(SPEED_OFFSET, {CREEP_SPEED_RESET, HOMING_SPEED_RESET}, RESP_OKAY);
		axi_rd(MODE_OFFSET, 32'h0000_0010, RESP_OKAY);
		axi_rd(SHIFT_OFFSET, SHIFT_RESET, RESP_OKAY);
		axi_wr(REVERSE_TRAVEL_OFFSET, 32'h0000_0123, RESP_OKAY);
		axi_rd(EFFECTIVE_TRAVEL_OFFSET, 32'h0000_0123, RESP_OKAY);
		axi_wr(MODE_OFFSET, {30'h0, START_CONDITION}, RESP_OKAY);
		axi_rd(EFFECTIVE_TRAVEL_OFFSET, 32'h0, RESP_OKAY);
		axi_wr(STATUS_OFFSET, 32'hFFFF_FFFF, RESP_OKAY);
		axi_rd(STATUS_OFFSET, 32'h0000_0006, RESP_OKAY);
		axi_rd(8'h20, 32'h0, RESP_SLVERR);
		axi_wr(8'h22, 32'h0, RESP_SLVERR);
	endtask

	task automatic sc_outside;
		logic r, p;
		axi_wr(MODE_OFFSET, MODE_COND, RESP_OKAY);
		place(32'sh0);
		go(1'b0);
		finish_run(r, p);
		chk(r === 1'b1 && p === 1'b1, "no reversal");
	endtask

	task automatic sc_inside;
		logic r, p;
		place(32'sh0FA0);
		go(1'b1);
		finish_run(r, p);
		chk(p === 1'b1, "no stop at release");
	endtask

	// Unqualified condition start, cut by a mid-run reset
	task automatic sc_unqualified;
		axi_wr(MODE_OFFSET, 32'h0000_0312, RESP_OKAY);
		place(32'sh0FA0);
		go(1'b0);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		#1;
		chk(homing_busy === 1'b0 && speed_command === 16'h0000, "reset abort");
		@(posedge aclk);
		aresetn <= 1'b1;
	endtask

	// ==========================================
	// Main sequence
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		sc_default();
		sc_regs();
		sc_outside();
		sc_inside();
		sc_unqualified();
		repeat (4) @(posedge aclk);
		report_and_stop();
	end
endmodule

`default_nettype wire
